// ### src/dnp_norm_path.sv
// Purpose: Dynamic normalisation and table mapping path with statistics monitor
// Assumes: Result bus and host bus both on hclk; single-word AHB-Lite transfers
// Notes:   Zero-wait-state slave; output result two cycles after the input sample
//
// Notes on behaviour
// - Dynamic normalisation is active only while backend_control_four bit 2 is set.
// - A field from a settable result-bus position addresses the table: 6 bits in dynamic mode, 8 bits otherwise.
// - Table bits 22 to 26 set the normaliser scale for each sample.
// - Output adder adds table bits 0 to 21 as offset to normaliser result.
// - In dynamic mode the result equals input scaled by upper table field plus low 22-bit offset.
// - Each table entry is one 32-bit word, byte 3 most significant.
// - Scale value is the count of arithmetic right shifts; zero is unity gain.
// - Table-access bit clear gives host writes; set hands table to datapath.
// - Without dynamic normalisation the table maps 8-bit input to 8-bit output.
// - In dynamic mode the address is the upper six bits of the 8-bit slice.
// - Monitor offers maximum and minimum tracking of the result bus.
// - In maximum mode the extreme register keeps the highest result since load.
// - Host loads the extreme register with the most negative value before a maximum search.
// - Counter counts results above threshold, or below it in under mode, and saturates, never wraps.

`timescale 1ns/1ns

module dnp_norm_path
   import dnp_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // Result bus from the multiply-accumulator array
   input  wire dnp_sample_s       xbus_in,
   // Post-processed output
   output dnp_sample_s            result_out
);

   // Elaboration checks; the logic below serves no other geometry
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
      $error("dnp_norm_path: CNT_W must lie in 1..32");
   end
   if (TBL_DEPTH != (1 << TBL_AW)) begin : g_bad_tbl
      $error("dnp_norm_path: table depth must be two to the table address width");
   end
   if (DYN_AW > SLICE_W || SLICE_W > TBL_AW || SLICE_W > XBUS_W) begin : g_bad_slice
      $error("dnp_norm_path: slice and table widths do not fit the result bus");
   end
   if (SLICE_POS_MAX >= (1 << SLICE_POS_W)) begin : g_bad_pos
      $error("dnp_norm_path: slice position register too narrow");
   end

   localparam logic [CNT_W-1:0] CNT_SAT = {CNT_W{1'b1}};

   typedef struct packed {
      logic [7:0]                       sys_ctl;
      logic [7:0]                       arith_ctl;
      logic [7:0]                       bc_one;
      logic [7:0]                       bc_two;
      logic [7:0]                       bc_three;
      logic [7:0]                       bc_four;
      logic [XBUS_W-1:0]                extreme;
      logic [XBUS_W-1:0]                threshold;
      logic [CNT_W-1:0]                 count;
      logic [SLICE_POS_W-1:0]           slice_pos;
      logic                             dph_wr;
      dnp_sel_e                         dph_sel;
      logic [TBL_AW-1:0]                dph_idx;
      logic [31:0]                      rdata;
      logic                             s1_valid;
      logic                             s1_dyn;
      logic [XBUS_W-1:0]                s1_data;
      logic [TBL_AW-1:0]                s1_addr;
      logic                             out_valid;
      logic [XBUS_W-1:0]                out_data;
      logic [TBL_DEPTH-1:0][31:0]       table_mem;
   } dnp_state_s;

   dnp_state_s state_q;
   dnp_state_s state_d;

   // Address decode shared by the address phase and read-back
   function automatic dnp_sel_e dnp_decode(input logic [11:0] a);
      dnp_sel_e s;
      s = DNP_SEL_NONE;
      if (a[11:10] == TBL_WIN_TAG) begin
         s = DNP_SEL_TBL;
      end else if (a == ADDR_SYS_CTL) begin
         s = DNP_SEL_SYS;
      end else if (a == ADDR_ARITH_CTL) begin
         s = DNP_SEL_ARITH;
      end else if (a == ADDR_BC_ONE) begin
         s = DNP_SEL_BC1;
      end else if (a == ADDR_BC_TWO) begin
         s = DNP_SEL_BC2;
      end else if (a == ADDR_BC_THREE) begin
         s = DNP_SEL_BC3;
      end else if (a == ADDR_BC_FOUR) begin
         s = DNP_SEL_BC4;
      end else if (a == ADDR_EXTREME) begin
         s = DNP_SEL_EXT;
      end else if (a == ADDR_COUNTER) begin
         s = DNP_SEL_CNT;
      end else if (a == ADDR_THRESHOLD) begin
         s = DNP_SEL_THR;
      end else if (a == ADDR_SLICE_POS) begin
         s = DNP_SEL_POS;
      end else if (a == ADDR_LAST_OUT) begin
         s = DNP_SEL_LAST;
      end
      return s;
   endfunction

   function automatic logic [31:0] sext(input logic [XBUS_W-1:0] v);
      return {{(32 - XBUS_W){v[XBUS_W-1]}}, v};
   endfunction

   // Datapath and bus working values
   logic                       addr_take;
   dnp_sel_e                   addr_sel;
   logic                       tbl_owned;
   logic                       dyn_mode;
   logic [SLICE_POS_W-1:0]     pos_eff;
   logic [XBUS_W-1:0]          shifted_in;
   logic [SLICE_W-1:0]         slice;
   logic [31:0]                lut_word;
   logic [4:0]                 scale;
   logic [XBUS_W-1:0]          offset;
   logic [XBUS_W-1:0]          normalised;
   logic                       hit;
   logic [31:0]                rd_val;
   dnp_mon_e                   mon_mode;

   always_comb begin
      state_d    = state_q;
      tbl_owned  = state_q.arith_ctl[TBL_OWN_BIT];
      dyn_mode   = state_q.bc_four[DYN_EN_BIT];
      mon_mode   = dnp_mon_e'({state_q.bc_two[MON_HI_BIT], state_q.bc_two[MON_LO_BIT]});
      addr_take  = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
      addr_sel   = dnp_decode(haddr[11:0]);
      hit        = 1'b0;
      rd_val     = WORD_RST;

      // Data phase write; a hardware event in the same cycle still counts below
      if (state_q.dph_wr) begin
         case (state_q.dph_sel)
            DNP_SEL_SYS: begin
               state_d.sys_ctl   = hwdata[7:0];
            end
            DNP_SEL_ARITH: begin
               state_d.arith_ctl = hwdata[7:0];
            end
            DNP_SEL_BC1: begin
               state_d.bc_one    = hwdata[7:0];
            end
            DNP_SEL_BC2: begin
               state_d.bc_two    = hwdata[7:0];
            end
            DNP_SEL_BC3: begin
               state_d.bc_three  = hwdata[7:0];
            end
            DNP_SEL_BC4: begin
               state_d.bc_four   = hwdata[7:0];
            end
            DNP_SEL_EXT: begin
               state_d.extreme   = hwdata[XBUS_W-1:0];
            end
            DNP_SEL_CNT: begin
               state_d.count     = hwdata[CNT_W-1:0];
            end
            DNP_SEL_THR: begin
               state_d.threshold = hwdata[XBUS_W-1:0];
            end
            DNP_SEL_POS: begin
               state_d.slice_pos = hwdata[SLICE_POS_W-1:0];
            end
            DNP_SEL_TBL: begin
               // Writes are dropped once the datapath owns the table
               if (!tbl_owned) begin
                  state_d.table_mem[state_q.dph_idx] = hwdata;
               end
            end
            default: begin
            end
         endcase
      end

      // Statistics monitor on the incoming result bus
      if (xbus_in.valid) begin
         case (mon_mode)
            DNP_MON_MAX: begin
               if ($signed(xbus_in.data) > $signed(state_d.extreme)) begin
                  state_d.extreme = xbus_in.data;
               end
            end
            DNP_MON_MIN: begin
               if ($signed(xbus_in.data) < $signed(state_d.extreme)) begin
                  state_d.extreme = xbus_in.data;
               end
            end
            DNP_MON_OVER: begin
               hit = $signed(xbus_in.data) > $signed(state_q.threshold);
            end
            default: begin
               hit = $signed(xbus_in.data) < $signed(state_q.threshold);
            end
         endcase
      end
      // Saturate so the host can tell overflow from a small count
      if (hit && (state_d.count != CNT_SAT)) begin
         state_d.count = state_d.count + CNT_W'(1);
      end

      // Stage 1: slice the result bus into a table address
      pos_eff = state_q.slice_pos;
      if (pos_eff > SLICE_POS_W'(SLICE_POS_MAX)) begin
         pos_eff = SLICE_POS_W'(SLICE_POS_MAX);
      end
      shifted_in = xbus_in.data >> pos_eff;
      slice      = shifted_in[SLICE_W-1:0];
      state_d.s1_valid = xbus_in.valid && tbl_owned;
      state_d.s1_data  = xbus_in.data;
      state_d.s1_dyn   = dyn_mode;
      if (dyn_mode) begin
         state_d.s1_addr = {{(TBL_AW - DYN_AW){1'b0}},
                            slice[SLICE_W-1:SLICE_W-DYN_AW]};
      end else begin
         state_d.s1_addr = slice;
      end

      // Stage 2: table lookup, normaliser and output adder
      lut_word   = state_q.table_mem[state_q.s1_addr];
      scale      = lut_word[SCALE_MSB:SCALE_LSB];
      offset     = lut_word[OFFSET_MSB:OFFSET_LSB];
      normalised = XBUS_W'($signed(state_q.s1_data) >>> scale);
      state_d.out_valid = state_q.s1_valid;
      if (state_q.s1_valid) begin
         if (state_q.s1_dyn) begin
            state_d.out_data = normalised + offset;
         end else begin
            state_d.out_data = {{(XBUS_W - MAP_MSB - 1){1'b0}}, lut_word[MAP_MSB:0]};
         end
      end

      // Address phase; read data comes from the updated copy so a write just
      // ahead of a read to the same register is seen
      state_d.dph_wr = 1'b0;
      if (addr_take) begin
         state_d.dph_wr  = hwrite;
         state_d.dph_sel = addr_sel;
         state_d.dph_idx = haddr[TBL_AW+1:2];
         if (!hwrite) begin
            case (addr_sel)
               DNP_SEL_SYS: begin
                  rd_val = {24'h00_0000, state_d.sys_ctl};
               end
               DNP_SEL_ARITH: begin
                  rd_val = {24'h00_0000, state_d.arith_ctl};
               end
               DNP_SEL_BC1: begin
                  rd_val = {24'h00_0000, state_d.bc_one};
               end
               DNP_SEL_BC2: begin
                  rd_val = {24'h00_0000, state_d.bc_two};
               end
               DNP_SEL_BC3: begin
                  rd_val = {24'h00_0000, state_d.bc_three};
               end
               DNP_SEL_BC4: begin
                  rd_val = {24'h00_0000, state_d.bc_four};
               end
               DNP_SEL_EXT: begin
                  rd_val = sext(state_d.extreme);
               end
               DNP_SEL_CNT: begin
                  rd_val = 32'(state_d.count);
               end
               DNP_SEL_THR: begin
                  rd_val = sext(state_d.threshold);
               end
               DNP_SEL_POS: begin
                  rd_val = 32'(state_d.slice_pos);
               end
               DNP_SEL_LAST: begin
                  rd_val = sext(state_q.out_data);
               end
               DNP_SEL_TBL: begin
                  rd_val = state_d.table_mem[haddr[TBL_AW+1:2]];
               end
               default: begin
                  rd_val = WORD_RST;
               end
            endcase
         end
         state_d.rdata = rd_val;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q.sys_ctl   <= CTL_RST;
         state_q.arith_ctl <= CTL_RST;
         state_q.bc_one    <= CTL_RST;
         state_q.bc_two    <= CTL_RST;
         state_q.bc_three  <= CTL_RST;
         state_q.bc_four   <= CTL_RST;
         state_q.extreme   <= '0;
         state_q.threshold <= '0;
         state_q.count     <= '0;
         state_q.slice_pos <= '0;
         state_q.dph_wr    <= 1'b0;
         state_q.dph_sel   <= DNP_SEL_NONE;
         state_q.dph_idx   <= '0;
         state_q.rdata     <= WORD_RST;
         state_q.s1_valid  <= 1'b0;
         state_q.s1_dyn    <= 1'b0;
         state_q.s1_data   <= '0;
         state_q.s1_addr   <= '0;
         state_q.out_valid <= 1'b0;
         state_q.out_data  <= '0;
         state_q.table_mem <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // Zero wait states; every transfer answers OKAY
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign hrdata            = state_q.rdata;
   assign result_out.valid  = state_q.out_valid;
   assign result_out.data   = state_q.out_data;

endmodule

// ### src/dnp_pkg.sv
// Purpose: Constants and types shared by the dynamic normalisation path
// Assumes: One clock, AHB-Lite register access, 22-bit result bus
// Notes:   Byte addresses of all registers live here

package dnp_pkg;

   // Datapath geometry
   localparam int          XBUS_W       = 22;
   localparam int          SLICE_W      = 8;
   localparam int          TBL_DEPTH    = 256;
   localparam int          TBL_AW       = 8;
   localparam int          DYN_AW       = 6;
   localparam int          SLICE_POS_W  = 5;
   localparam int          SLICE_POS_MAX = XBUS_W - SLICE_W;

   // Table word layout
   localparam int          OFFSET_LSB   = 0;
   localparam int          OFFSET_MSB   = 21;
   localparam int          SCALE_LSB    = 22;
   localparam int          SCALE_MSB    = 26;
   localparam int          MAP_MSB      = 7;

   // Control bit positions
   localparam int          DYN_EN_BIT   = 2;
   localparam int          TBL_OWN_BIT  = 1;
   localparam int          MON_LO_BIT   = 0;
   localparam int          MON_HI_BIT   = 1;

   // Byte addresses within the slave window
   localparam logic [11:0] ADDR_SYS_CTL   = 12'h000;
   localparam logic [11:0] ADDR_ARITH_CTL = 12'h004;
   localparam logic [11:0] ADDR_BC_ONE    = 12'h008;
   localparam logic [11:0] ADDR_BC_TWO    = 12'h00c;
   localparam logic [11:0] ADDR_BC_THREE  = 12'h010;
   localparam logic [11:0] ADDR_BC_FOUR   = 12'h014;
   localparam logic [11:0] ADDR_EXTREME   = 12'h018;
   localparam logic [11:0] ADDR_COUNTER   = 12'h01c;
   localparam logic [11:0] ADDR_THRESHOLD = 12'h020;
   localparam logic [11:0] ADDR_SLICE_POS = 12'h024;
   localparam logic [11:0] ADDR_LAST_OUT  = 12'h028;
   localparam logic [1:0]  TBL_WIN_TAG    = 2'h1;

   // Reset values
   localparam logic [7:0]  CTL_RST        = 8'h00;
   localparam logic [31:0] WORD_RST       = 32'h0000_0000;

   // AHB encodings
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

   // Statistics monitor modes
   typedef enum logic [1:0] {
      DNP_MON_MIN   = 2'h0,
      DNP_MON_MAX   = 2'h1,
      DNP_MON_UNDER = 2'h2,
      DNP_MON_OVER  = 2'h3
   } dnp_mon_e;

   // Register selector from address decode
   typedef enum logic [3:0] {
      DNP_SEL_NONE, DNP_SEL_SYS, DNP_SEL_ARITH, DNP_SEL_BC1, DNP_SEL_BC2,
      DNP_SEL_BC3, DNP_SEL_BC4, DNP_SEL_EXT, DNP_SEL_CNT, DNP_SEL_THR,
      DNP_SEL_POS, DNP_SEL_LAST, DNP_SEL_TBL
   } dnp_sel_e;

   // Sample on the result bus or at the output adder
   typedef struct packed {
      logic                valid;
      logic [XBUS_W-1:0]   data;
   } dnp_sample_s;

endpackage

// ### testbench/dnp_norm_path_sva.sv
// Purpose: Port-level checks of the normalisation path
// Assumes: Control bits mirrored from observed AHB writes
// Notes:   Bound to every dnp_norm_path instance
`timescale 1ns/1ns
module dnp_norm_path_sva
   import dnp_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // AHB-Lite slave
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Stream
   input wire dnp_sample_s xbus_in,
   input wire dnp_sample_s result_out
);
   logic        acc;
   logic        wr_q;
   logic        own_q;
   logic        dyn_q;
   logic [11:0] adr_q;
   assign acc = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
   // Mirror only the two bits that gate the stream
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q  <= 1'b0;
         adr_q <= 12'h000;
         own_q <= 1'b0;
         dyn_q <= 1'b0;
      end else begin
         wr_q  <= acc && hwrite;
         adr_q <= haddr[11:0];
         if (wr_q && adr_q == ADDR_ARITH_CTL) begin
            own_q <= hwdata[TBL_OWN_BIT];
         end
         if (wr_q && adr_q == ADDR_BC_FOUR) begin
            dyn_q <= hwdata[DYN_EN_BIT];
         end
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_take_own;
      xbus_in.valid && own_q;
   endsequence
   sequence s_take_host;
      xbus_in.valid && !own_q;
   endsequence
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_okay_resp: assert property (hresp == 1'b0) else $error("hresp not okay");
   a_own_output: assert property (s_take_own |-> ##2 result_out.valid)
      else $error("missing output");
   a_host_blocks: assert property (s_take_host |-> ##2 !result_out.valid)
      else $error("output while host owns table");
   a_out_cause: assert property (result_out.valid |-> $past(xbus_in.valid, 2))
      else $error("output without sample");
   a_map_narrow: assert property (result_out.valid && !$past(dyn_q, 2)
      |-> result_out.data[21:8] == 14'h0000) else $error("map output too wide");
   a_rdata_hold: assert property (!$past(acc) |-> $stable(hrdata))
      else $error("hrdata moved");
   a_write_clears: assert property (acc && hwrite |=> hrdata == 32'h0000_0000)
      else $error("hrdata not cleared on write");
endmodule
bind dnp_norm_path dnp_norm_path_sva #(.CNT_W(CNT_W)) u_sva (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .xbus_in,
   .result_out);

// ### testbench/dnp_xbus_src.sv
// Purpose: Result-bus source standing in for the accumulator array
// Assumes: One sample per push, back to back allowed
// Notes:   Idle data is inverted so stale values never look valid
`timescale 1ns/1ns
module dnp_xbus_src
   import dnp_pkg::*;
(
   // Clock
   input  wire logic  hclk,
   // Result bus
   output dnp_sample_s xbus
);
   initial xbus = '0;
   task push(input logic [21:0] d);
      @(posedge hclk);
      xbus <= '{valid: 1'b1, data: d};
   endtask
   task stop();
      @(posedge hclk);
      xbus <= '{valid: 1'b0, data: ~xbus.data};
   endtask
endmodule

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the normalisation path
// Assumes: Zero-wait AHB slave, two-stage stream
// Notes:   Small counter width to reach saturation fast
`timescale 1ns/1ns
module testbench
   import dnp_pkg::*;
;
   localparam int CNT = 4;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic        hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rd;
   dnp_sample_s xbus;
   dnp_sample_s res;
   int          error_cnt;
   int          checks_done;
   logic [31:0] tbl [256] = '{default: 32'h0};
   logic [21:0] smp [$];
   logic [21:0] outs [$];

   dnp_norm_path #(.CNT_W(CNT)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .xbus_in(xbus),
      .result_out(res));
   dnp_xbus_src u_src (.hclk, .xbus);

   initial hclk = 1'b0;
   always #25 hclk = ~hclk;
   always @(posedge hclk) if (res.valid === 1'b1) outs.push_back(res.data);

   task report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize  <= HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   function logic [11:0] tadr(input int i);
      return {TBL_WIN_TAG, 8'(i), 2'b00};
   endfunction
   function logic [21:0] model(input logic [21:0] d, input logic dyn, input logic [4:0] pos);
      logic [7:0]         s;
      logic [31:0]        w;
      logic signed [21:0] sh;
      s = 8'(d >> pos);
      w = tbl[dyn ? {2'b00, s[7:2]} : s];
      sh = $signed(d) >>> w[26:22];
      return dyn ? sh + w[21:0] : {14'h0000, w[7:0]};
   endfunction
   // Output count and values; none expected while the host holds the table
   task play(input logic own, input logic dyn, input logic [4:0] pos);
      outs.delete();
      foreach (smp[i]) u_src.push(smp[i]);
      u_src.stop();
      repeat (4) @(posedge hclk);
      check(32'(outs.size()), own ? 32'(smp.size()) : 32'h0);
      if (own) foreach (smp[i]) check({10'h000, outs[i]}, {10'h000, model(smp[i], dyn, pos)});
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      error_cnt = 0;
      checks_done = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(ADDR_EXTREME, 32'h0);
      wr(ADDR_BC_FOUR, 32'h4);
      rdc(ADDR_BC_FOUR, 32'h4);
      rdc(12'h030, 32'h0);
      wr(ADDR_SYS_CTL, 32'h0000_00a5);
      wr(ADDR_BC_ONE, 32'h0000_005a);
      wr(ADDR_BC_THREE, 32'h0000_003c);
      wr(ADDR_THRESHOLD, 32'h0020_0001);
      rdc(ADDR_SYS_CTL, 32'h0000_00a5);
      rdc(ADDR_BC_ONE, 32'h0000_005a);
      rdc(ADDR_BC_THREE, 32'h0000_003c);
      rdc(ADDR_THRESHOLD, 32'hffe0_0001);
      wr(ADDR_THRESHOLD, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 64; i++) begin
         tbl[i] = (i == 0) ? 32'h0 : (i < 16) ? 32'h00c0_0038 : 32'h0180_00a8;
         wr(tadr(i), tbl[i]);
      end
      rdc(tadr(15), 32'h00c0_0038);
      wr(ADDR_ARITH_CTL, 32'h2);
      wr(tadr(1), 32'h0123_4567);
      rdc(tadr(1), 32'h00c0_0038);
      $display("test table done");
      wr(ADDR_SLICE_POS, 32'h4);
      smp = '{22'd63, 22'd100, 22'd1023, 22'd1024, 22'd4095, 22'h3fffc0};
      play(1'b1, 1'b1, 5'd4);
      $display("test dynamic done");
      wr(ADDR_BC_FOUR, 32'h0);
      wr(ADDR_SLICE_POS, 32'h0);
      smp = '{22'h1, 22'h20, 22'h45, 22'h3fff0f};
      play(1'b1, 1'b0, 5'd0);
      rdc(ADDR_LAST_OUT, {24'h00_0000, tbl[15][7:0]});
      wr(ADDR_ARITH_CTL, 32'h0);
      play(1'b0, 1'b0, 5'd0);
      $display("test mapping done");
      wr(ADDR_BC_TWO, 32'h1);
      wr(ADDR_EXTREME, 32'hffe0_0000);
      smp = '{22'd5, 22'h3ffffd, 22'd100, 22'd7};
      play(1'b0, 1'b0, 5'd0);
      rdc(ADDR_EXTREME, 32'd100);
      wr(ADDR_BC_TWO, 32'h0);
      wr(ADDR_EXTREME, 32'h0);
      play(1'b0, 1'b0, 5'd0);
      rdc(ADDR_EXTREME, 32'hffff_fffd);
      wr(ADDR_BC_TWO, 32'h3);
      wr(ADDR_THRESHOLD, 32'd10);
      wr(ADDR_COUNTER, 32'h0);
      smp.delete();
      repeat (20) smp.push_back(22'd11);
      play(1'b0, 1'b0, 5'd0);
      rdc(ADDR_COUNTER, 32'hf);
      wr(ADDR_BC_TWO, 32'h2);
      wr(ADDR_COUNTER, 32'h0);
      smp = '{22'd9, 22'd10, 22'd11};
      play(1'b0, 1'b0, 5'd0);
      rdc(ADDR_COUNTER, 32'h1);
      $display("test monitor done");
      report_and_stop();
   end

   // Whole run needs about 390 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      report_and_stop();
   end
endmodule
